// ==== src/acs_pkg.sv ====
// Shared constants, codes and types of the system clock select block
package acs_pkg;

	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_PERIOD_NS   = 4;      // Core clock period, 250 MHz
	localparam int SETTLE_TIME_NS  = 2000;   // Least clock settle time
	localparam int SETTLE_CYCLES   =
		(SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STRAP_DELAY     = 3;      // Cycles after reset to latch
	localparam int MCLK_TIMEOUT    = 64;     // Cycles with no master edge
	localparam int PERIOD_W        = 14;     // Frame period counter width

	// ****************************************
	// Sample rate codes
	// ****************************************
	localparam logic [3:0] RATE_AUTO  = 4'h0;
	localparam logic [3:0] RATE_32K   = 4'h1;
	localparam logic [3:0] RATE_44K1  = 4'h2;
	localparam logic [3:0] RATE_48K   = 4'h3;
	localparam logic [3:0] RATE_88K2  = 4'h4;
	localparam logic [3:0] RATE_96K   = 4'h5;
	localparam logic [3:0] RATE_176K4 = 4'h6;
	localparam logic [3:0] RATE_192K  = 4'h7;
	localparam logic [3:0] RATE_352K8 = 4'h8;
	localparam logic [3:0] RATE_384K  = 4'h9;
	localparam logic [3:0] RATE_705K6 = 4'ha;
	localparam logic [3:0] RATE_768K  = 4'hb;

	// ****************************************
	// Hardware clock setups and data formats
	// ****************************************
	localparam logic [1:0] SETUP_BCLK64   = 2'h0;  // Bit clock, PLL on
	localparam logic [1:0] SETUP_MCLK1024 = 2'h1;  // Master clock, bypass
	localparam logic [1:0] SETUP_MCLK256  = 2'h2;  // Master clock, PLL on
	localparam logic [1:0] SETUP_MCLK512  = 2'h3;  // Master clock, PLL on
	localparam logic [1:0] FMT_I2S        = 2'h0;
	localparam logic [1:0] FMT_LJ         = 2'h1;
	localparam logic [1:0] FMT_TDM_MIN    = 2'h2;
	localparam logic [1:0] FMT_TDM_MAX    = 2'h3;

	// ****************************************
	// PLL reference frequency codes
	// ****************************************
	localparam logic [1:0] FREQ_3M   = 2'h0;  // 2.8224 / 3.072 MHz
	localparam logic [1:0] FREQ_6M   = 2'h1;  // 5.6448 / 6.144 MHz
	localparam logic [1:0] FREQ_12M  = 2'h2;  // 11.2896 / 12.288 MHz
	localparam logic [1:0] FREQ_24M  = 2'h3;  // 22.5792 / 24.576 MHz

	// Frame period, in core cycles, per rate (rounded down)
	localparam int PER_32K  = 1000000 / (32 * CLK_PERIOD_NS);
	localparam int PER_44K1 = 10000000 / (441 * CLK_PERIOD_NS);
	localparam int PER_48K  = 1000000 / (48 * CLK_PERIOD_NS);
	localparam int PER_88K2 = 10000000 / (882 * CLK_PERIOD_NS);
	localparam int PER_96K  = 1000000 / (96 * CLK_PERIOD_NS);
	localparam int PER_176K = 10000000 / (1764 * CLK_PERIOD_NS);
	localparam int PER_192K = 1000000 / (192 * CLK_PERIOD_NS);
	localparam int PER_MAX  = PER_32K + PER_32K / 8;    // Too slow beyond
	localparam int PER_MIN  = PER_192K - PER_192K / 8;  // Too fast below

	// Active clock setup
	typedef struct packed {
		logic       pll_on;     // System clock from PLL
		logic       ref_bclk;   // PLL reference is bit clock
		logic [1:0] freq_code;  // PLL reference frequency code
		logic [3:0] rate;       // Requested sample rate code
	} acs_cfg_type;

	// Controller states, one-hot
	typedef enum logic [3:0] {
		ST_IDLE   = 4'b0001,
		ST_SETTLE = 4'b0010,
		ST_RUN    = 4'b0100,
		ST_FAULT  = 4'b1000
	} acs_state_type;

endpackage : acs_pkg

// ==== src/acs_sync.sv ====
// Two-stage synchroniser with rising edge pulse per bit
module acs_sync #(
	parameter int W = 1  // Number of bits
) (
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic [W-1:0] async_i,
	output logic      [W-1:0] level_o,
	output logic      [W-1:0] rise_o
);

	logic [W-1:0] meta_q;  // First stage, read by second only
	logic [W-1:0] sync_q;  // Second stage
	logic [W-1:0] prev_q;  // Delayed for edge finding

	// ****************************************
	// Synchroniser chain
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta_q <= '0;
			sync_q <= '0;
			prev_q <= '0;
		end else begin
			meta_q <= async_i;
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end

	assign level_o = sync_q;
	assign rise_o  = sync_q & ~prev_q;

endmodule : acs_sync

// ==== src/acs_settle.sv ====
// Counts a condition held without break; flags when it has held long enough
module acs_settle #(
	parameter int CYCLES = 500  // Cycles the condition must hold
) (
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic cond_i,   // Condition to watch
	output logic      done_o    // Held for CYCLES cycles
);

	localparam int CW = $clog2(CYCLES + 1);

	logic [CW-1:0] cnt_q;  // Cycles held so far

	// ****************************************
	// Hold counter, restarts on any break
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (rst_i || !cond_i) begin
			cnt_q <= '0;
		end else if (cnt_q != CW'(CYCLES)) begin
			cnt_q <= cnt_q + CW'(1);
		end
	end

	assign done_o = (cnt_q == CW'(CYCLES));

endmodule : acs_settle

// ==== src/acs_clk_sel.sv ====
// System clock selection, checking and frame timing for an audio codec

// Operation
// - Bit clock reference always goes through PLL
// - Master clock may drive system clock directly
// - Secondary mode times conversion from frame sync
// - Hardware strap picks one of four setups
// - Base rate is 48k or 44.1k family
// - Hardware autodetect needs master clock, secondary mode
// - Bit clock setup rejects maximum slot TDM
// - Bit clock setup: secondary, 44.1-192k, no autodetect
// - Master clock setups: either mode, 32-192k, autodetect
// - Software rate field: 32-768k or autodetect
// - Software autodetect: 32-192k, master ref, secondary
// - Source field: 0 bypass, 1 PLL output
// - Reference field: 1 master, 0 bit clock
// - Two-bit reference frequency code encodings
// - Each family supports its own rate list
// - Software settings apply on enable rising edge
// - Strap setup latched at reset release
// - Bypass ignores reference frequency code
module acs_clk_sel #(
	parameter int SETTLE_CYCLES = acs_pkg::SETTLE_CYCLES  // Settle count
) (
	input  wire logic       REF_CLK_I,                 // Core clock
	input  wire logic       SYS_RST_I,                 // Sync reset, high
	input  wire logic       HW_MODE_STRAP_I,           // Hardware mode pin
	input  wire logic [1:0] CLOCK_SETUP_STRAP_PIN_I,   // Decoded setup pin
	input  wire logic [3:0] RATE_SELECT_STRAP_PIN_I,   // Decoded rate pin
	input  wire logic       GLOBAL_EN_I,               // Software enable
	input  wire logic       CORE_CLOCK_SOURCE_SEL_I,   // 0 bypass, 1 PLL
	input  wire logic       PLL_INPUT_SOURCE_SEL_I,    // 1 master, 0 bit
	input  wire logic [1:0] PLL_INPUT_FREQ_CODE_I,     // Reference code
	input  wire logic [3:0] SAMPLE_RATE_I,             // Software rate
	input  wire logic       AUDIO_SERIAL_PORT_SECONDARY_I, // Secondary
	input  wire logic [1:0] AUDIO_SERIAL_PORT_FORMAT_I,    // Data format
	input  wire logic       MCLK_I,                    // Master clock pin
	input  wire logic       BCLK_I,                    // Bit clock pin
	input  wire logic       FSYNC_I,                   // Frame sync pin
	input  wire logic       PLL_LOCK_I,                // PLL lock, async
	output logic            PLL_ENABLE_O,              // PLL powered
	output logic            SYSCLK_FROM_PLL_O,         // Core mux select
	output logic            PLL_REF_IS_BCLK_O,         // PLL input mux
	output logic [1:0]      PLL_FREQ_CODE_O,           // PLL divider code
	output logic            BASE_IS_48K_O,             // Family of rate
	output logic [3:0]      ACTIVE_RATE_O,             // Rate in use
	output logic            AUTODETECT_ON_O,           // Rate from port
	output logic            CONFIG_ERROR_O,            // Setup refused
	output logic            DATAPATH_RUN_O,            // Datapath allowed
	output logic            CONVERT_STROBE_O           // Sample instant
);

	// ****************************************
	// Pin synchronisers
	// ****************************************
	localparam int NSYNC = 11;
	logic [NSYNC-1:0] pin_lvl;   // Synchronised pins
	logic [NSYNC-1:0] pin_rise;  // Their rising edges

	acs_sync #(
		.W (NSYNC)
	) u_sync (
		.clk_i   (REF_CLK_I),
		.rst_i   (SYS_RST_I),
		.async_i ({RATE_SELECT_STRAP_PIN_I, CLOCK_SETUP_STRAP_PIN_I,
		           HW_MODE_STRAP_I, PLL_LOCK_I, FSYNC_I, BCLK_I, MCLK_I}),
		.level_o (pin_lvl),
		.rise_o  (pin_rise)
	);

	logic       mclk_rise;   // Master clock edge
	logic       fsync_rise;  // Frame sync edge
	logic       lock_s;      // PLL locked
	logic       hw_s;        // Hardware mode strap
	logic [1:0] setup_s;     // Setup strap
	logic [3:0] rate_s;      // Rate strap

	assign mclk_rise  = pin_rise[0];
	assign fsync_rise = pin_rise[2];
	assign lock_s     = pin_lvl[3];
	assign hw_s       = pin_lvl[4];
	assign setup_s    = pin_lvl[6:5];
	assign rate_s     = pin_lvl[10:7];

	// ****************************************
	// Strap latch after reset release
	// ****************************************
	logic [1:0] strap_cnt_q;    // Waits for synchronisers to fill
	logic       strap_done_q;   // Straps captured
	logic       hw_mode_q;      // Latched mode
	logic [1:0] hw_setup_q;     // Latched setup
	logic [3:0] hw_rate_q;      // Latched rate

	always_ff @(posedge REF_CLK_I) begin
		if (SYS_RST_I) begin
			strap_cnt_q  <= 2'h0;
			strap_done_q <= 1'b0;
			hw_mode_q    <= 1'b0;
			hw_setup_q   <= acs_pkg::SETUP_BCLK64;
			hw_rate_q    <= acs_pkg::RATE_AUTO;
		end else if (!strap_done_q) begin
			if (strap_cnt_q == 2'(acs_pkg::STRAP_DELAY)) begin
				// Held until next reset
				strap_done_q <= 1'b1;
				hw_mode_q    <= hw_s;
				hw_setup_q   <= setup_s;
				hw_rate_q    <= rate_s;
			end else begin
				strap_cnt_q <= strap_cnt_q + 2'h1;
			end
		end
	end

	// ****************************************
	// Software fields, taken on enable edge
	// ****************************************
	logic                ge_q;      // Enable delayed
	logic                ge_rise;   // Enable rising edge
	acs_pkg::acs_cfg_type sw_cfg_q; // Captured software setup

	assign ge_rise = GLOBAL_EN_I & ~ge_q;

	always_ff @(posedge REF_CLK_I) begin
		if (SYS_RST_I) begin
			ge_q     <= 1'b0;
			sw_cfg_q <= '0;
		end else begin
			ge_q <= GLOBAL_EN_I;
			// Writes at other times have no effect
			if (ge_rise) begin
				sw_cfg_q.pll_on    <= CORE_CLOCK_SOURCE_SEL_I;
				sw_cfg_q.ref_bclk  <= ~PLL_INPUT_SOURCE_SEL_I;
				sw_cfg_q.freq_code <= PLL_INPUT_FREQ_CODE_I;
				sw_cfg_q.rate      <= SAMPLE_RATE_I;
			end
		end
	end

	// ****************************************
	// Active setup: strap decode or software
	// ****************************************
	acs_pkg::acs_cfg_type cfg;  // Setup in force

	always_comb begin
		cfg = sw_cfg_q;
		if (hw_mode_q) begin
			cfg.rate = hw_rate_q;
			case (hw_setup_q)
				acs_pkg::SETUP_BCLK64: begin
					// Bit clock only via PLL, code from rate
					cfg.pll_on   = 1'b1;
					cfg.ref_bclk = 1'b1;
					case (hw_rate_q)
						acs_pkg::RATE_88K2,
						acs_pkg::RATE_96K:  cfg.freq_code = acs_pkg::FREQ_6M;
						acs_pkg::RATE_176K4,
						acs_pkg::RATE_192K: cfg.freq_code = acs_pkg::FREQ_12M;
						default:            cfg.freq_code = acs_pkg::FREQ_3M;
					endcase
				end
				acs_pkg::SETUP_MCLK1024: begin
					cfg.pll_on    = 1'b0;  // Direct master clock
					cfg.ref_bclk  = 1'b0;
					cfg.freq_code = acs_pkg::FREQ_3M;
				end
				acs_pkg::SETUP_MCLK256: begin
					cfg.pll_on    = 1'b1;
					cfg.ref_bclk  = 1'b0;
					cfg.freq_code = acs_pkg::FREQ_12M;
				end
				default: begin
					cfg.pll_on    = 1'b1;
					cfg.ref_bclk  = 1'b0;
					cfg.freq_code = acs_pkg::FREQ_24M;
				end
			endcase
		end
		if (!cfg.pll_on) begin
			// Bypass: reference fields play no part
			cfg.ref_bclk  = 1'b0;
			cfg.freq_code = acs_pkg::FREQ_3M;
		end
	end

	// ****************************************
	// Rate autodetect from frame sync period
	// ****************************************
	logic [acs_pkg::PERIOD_W-1:0] per_cnt_q;  // Cycles since last frame
	logic [3:0]                   det_rate_q; // Detected rate
	logic                         det_ok_q;   // Detection valid

	always_ff @(posedge REF_CLK_I) begin
		if (SYS_RST_I) begin
			per_cnt_q  <= '0;
			det_rate_q <= acs_pkg::RATE_AUTO;
			det_ok_q   <= 1'b0;
		end else if (fsync_rise) begin
			per_cnt_q <= '0;
			det_ok_q  <= 1'b1;
			// Nearest rate by period midpoints, 32k to 192k only
			// A saturated count means frame sync was lost: not a period
			if (per_cnt_q >= 14'(acs_pkg::PER_MAX) ||
			    per_cnt_q < 14'(acs_pkg::PER_MIN)) begin
				det_ok_q   <= 1'b0;
				det_rate_q <= acs_pkg::RATE_AUTO;
			end else if (per_cnt_q >
			             14'((acs_pkg::PER_32K + acs_pkg::PER_44K1) / 2)) begin
				det_rate_q <= acs_pkg::RATE_32K;
			end else if (per_cnt_q >
			             14'((acs_pkg::PER_44K1 + acs_pkg::PER_48K) / 2)) begin
				det_rate_q <= acs_pkg::RATE_44K1;
			end else if (per_cnt_q >
			             14'((acs_pkg::PER_48K + acs_pkg::PER_88K2) / 2)) begin
				det_rate_q <= acs_pkg::RATE_48K;
			end else if (per_cnt_q >
			             14'((acs_pkg::PER_88K2 + acs_pkg::PER_96K) / 2)) begin
				det_rate_q <= acs_pkg::RATE_88K2;
			end else if (per_cnt_q >
			             14'((acs_pkg::PER_96K + acs_pkg::PER_176K) / 2)) begin
				det_rate_q <= acs_pkg::RATE_96K;
			end else if (per_cnt_q >
			             14'((acs_pkg::PER_176K + acs_pkg::PER_192K) / 2)) begin
				det_rate_q <= acs_pkg::RATE_176K4;
			end else begin
				det_rate_q <= acs_pkg::RATE_192K;
			end
		end else if (per_cnt_q == 14'(acs_pkg::PER_MAX)) begin
			// Frame sync lost
			det_ok_q   <= 1'b0;
			det_rate_q <= acs_pkg::RATE_AUTO;
		end else begin
			per_cnt_q <= per_cnt_q + 14'h1;
		end
	end

	// ****************************************
	// Setup checks
	// ****************************************
	logic       auto_req;   // Autodetect asked for
	logic [3:0] eff_rate;   // Rate in use
	logic       cfg_err;    // Setup not allowed
	logic       port_sec;   // Serial port is secondary
	logic [1:0] port_fmt;   // Serial port data format

	assign auto_req = (cfg.rate == acs_pkg::RATE_AUTO);
	assign eff_rate = auto_req ? det_rate_q : cfg.rate;
	assign port_sec = AUDIO_SERIAL_PORT_SECONDARY_I;
	assign port_fmt = AUDIO_SERIAL_PORT_FORMAT_I;

	always_comb begin
		cfg_err = 1'b0;
		// Rate codes beyond 768k are not defined
		if (cfg.rate > acs_pkg::RATE_768K) cfg_err = 1'b1;
		// Hardware setups reach 192k at most
		if (hw_mode_q && cfg.rate > acs_pkg::RATE_192K) cfg_err = 1'b1;
		// Autodetect needs master reference and secondary port
		if (auto_req && (cfg.ref_bclk || !port_sec)) begin
			cfg_err = 1'b1;
		end
		if (cfg.ref_bclk) begin
			if (!port_sec) cfg_err = 1'b1;
			if (port_fmt == acs_pkg::FMT_TDM_MAX) cfg_err = 1'b1;
			// Bit clock at 64 fs serves 44.1k to 192k
			if (hw_mode_q && (cfg.rate == acs_pkg::RATE_32K)) cfg_err = 1'b1;
		end
	end

	// ****************************************
	// Clock health and settle wait
	// ****************************************
	logic [6:0] mclk_idle_q;  // Cycles since last master edge
	logic       clk_ok;       // Selected clock usable
	logic       run_req;      // Enable asked for
	logic       settled;      // Usable for long enough

	always_ff @(posedge REF_CLK_I) begin
		if (SYS_RST_I || mclk_rise) begin
			mclk_idle_q <= 7'h0;
		end else if (mclk_idle_q != 7'(acs_pkg::MCLK_TIMEOUT)) begin
			mclk_idle_q <= mclk_idle_q + 7'h1;
		end
	end

	// PLL lock, or a running master clock when bypassed
	assign clk_ok  = cfg.pll_on ? lock_s
	                 : (mclk_idle_q != 7'(acs_pkg::MCLK_TIMEOUT));
	assign run_req = strap_done_q & (hw_mode_q | GLOBAL_EN_I);

	acs_settle #(
		.CYCLES (SETTLE_CYCLES)
	) u_settle (
		.clk_i  (REF_CLK_I),
		.rst_i  (SYS_RST_I),
		.cond_i (run_req & clk_ok & ~cfg_err),
		.done_o (settled)
	);

	// ****************************************
	// Controller
	// ****************************************
	acs_pkg::acs_state_type state_q;  // Controller state

	always_ff @(posedge REF_CLK_I) begin
		if (SYS_RST_I) begin
			state_q <= acs_pkg::ST_IDLE;
		end else begin
			case (state_q)
				acs_pkg::ST_IDLE: begin
					// Skip the enable edge: setup still the old one
					if (run_req && !ge_rise) begin
						state_q <= cfg_err ? acs_pkg::ST_FAULT
						           : acs_pkg::ST_SETTLE;
					end
				end
				acs_pkg::ST_SETTLE: begin
					// Datapath held idle meanwhile
					if (!run_req) state_q <= acs_pkg::ST_IDLE;
					else if (cfg_err) state_q <= acs_pkg::ST_FAULT;
					else if (settled) state_q <= acs_pkg::ST_RUN;
				end
				acs_pkg::ST_RUN: begin
					if (!run_req) state_q <= acs_pkg::ST_IDLE;
					else if (cfg_err) state_q <= acs_pkg::ST_FAULT;
					else if (!clk_ok) state_q <= acs_pkg::ST_SETTLE;
				end
				acs_pkg::ST_FAULT: begin
					// Left only by dropping enable; in hardware mode only by reset
					if (!run_req) state_q <= acs_pkg::ST_IDLE;
				end
				default: state_q <= acs_pkg::ST_IDLE;
			endcase
		end
	end

	// ****************************************
	// Conversion timing
	// ****************************************
	logic [acs_pkg::PERIOD_W-1:0] div_q;    // Primary frame divider
	logic [acs_pkg::PERIOD_W-1:0] div_max;  // Divider period
	logic                         running;  // In run state, rate known

	assign running = (state_q == acs_pkg::ST_RUN) & (~auto_req | det_ok_q);

	always_comb begin
		case (eff_rate)
			acs_pkg::RATE_32K:   div_max = 14'(acs_pkg::PER_32K - 1);
			acs_pkg::RATE_44K1:  div_max = 14'(acs_pkg::PER_44K1 - 1);
			acs_pkg::RATE_88K2:  div_max = 14'(acs_pkg::PER_88K2 - 1);
			acs_pkg::RATE_96K:   div_max = 14'(acs_pkg::PER_96K - 1);
			acs_pkg::RATE_176K4: div_max = 14'(acs_pkg::PER_176K - 1);
			acs_pkg::RATE_192K:  div_max = 14'(acs_pkg::PER_192K - 1);
			default:             div_max = 14'(acs_pkg::PER_48K - 1);
		endcase
	end

	always_ff @(posedge REF_CLK_I) begin
		if (SYS_RST_I || !running || div_q == div_max) begin
			div_q <= '0;
		end else begin
			div_q <= div_q + 14'h1;
		end
	end

	// ****************************************
	// Registered outputs
	// ****************************************
	always_ff @(posedge REF_CLK_I) begin
		if (SYS_RST_I) begin
			PLL_ENABLE_O      <= 1'b0;
			SYSCLK_FROM_PLL_O <= 1'b0;
			PLL_REF_IS_BCLK_O <= 1'b0;
			PLL_FREQ_CODE_O   <= acs_pkg::FREQ_3M;
			BASE_IS_48K_O     <= 1'b0;
			ACTIVE_RATE_O     <= acs_pkg::RATE_AUTO;
			AUTODETECT_ON_O   <= 1'b0;
			CONFIG_ERROR_O    <= 1'b0;
			DATAPATH_RUN_O    <= 1'b0;
			CONVERT_STROBE_O  <= 1'b0;
		end else begin
			PLL_ENABLE_O      <= run_req & cfg.pll_on & ~cfg_err;
			SYSCLK_FROM_PLL_O <= cfg.pll_on;
			PLL_REF_IS_BCLK_O <= cfg.ref_bclk;
			PLL_FREQ_CODE_O   <= cfg.freq_code;
			// 48k family: 32, 48, 96, 192, 384, 768
			case (eff_rate)
				acs_pkg::RATE_32K, acs_pkg::RATE_48K, acs_pkg::RATE_96K,
				acs_pkg::RATE_192K, acs_pkg::RATE_384K,
				acs_pkg::RATE_768K: BASE_IS_48K_O <= 1'b1;
				default:            BASE_IS_48K_O <= 1'b0;
			endcase
			ACTIVE_RATE_O     <= eff_rate;
			AUTODETECT_ON_O   <= auto_req & ~cfg_err;
			CONFIG_ERROR_O    <= (state_q == acs_pkg::ST_FAULT);
			DATAPATH_RUN_O    <= running;
			// Secondary follows frame sync, primary its divider
			CONVERT_STROBE_O  <= running & (port_sec ? fsync_rise
			                                : (div_q == div_max));
		end
	end

endmodule : acs_clk_sel

// ==== test/acs_clk_sel_checker.sv ====
// Concurrent checks on the ports of the system clock select block
module acs_clk_sel_checker (
	input wire logic       REF_CLK_I,
	input wire logic       SYS_RST_I,
	input wire logic       HW_MODE_STRAP_I,
	input wire logic       GLOBAL_EN_I,
	input wire logic       AUDIO_SERIAL_PORT_SECONDARY_I,
	input wire logic       FSYNC_I,
	input wire logic       PLL_ENABLE_O,
	input wire logic       SYSCLK_FROM_PLL_O,
	input wire logic       PLL_REF_IS_BCLK_O,
	input wire logic [1:0] PLL_FREQ_CODE_O,
	input wire logic       AUTODETECT_ON_O,
	input wire logic       CONFIG_ERROR_O,
	input wire logic       DATAPATH_RUN_O,
	input wire logic       CONVERT_STROBE_O
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge REF_CLK_I); endclocking
	default disable iff (SYS_RST_I);
	// Frame sync pin rises while running in secondary mode
	sequence fs_rise_s;
		$rose(FSYNC_I) && AUDIO_SERIAL_PORT_SECONDARY_I && DATAPATH_RUN_O;
	endsequence
	// Software enable rose two edges back
	sequence en_rise_s;
		$past(GLOBAL_EN_I, 2) && !$past(GLOBAL_EN_I, 3);
	endsequence
	bclk_via_pll_a: assert property (
		PLL_REF_IS_BCLK_O |-> SYSCLK_FROM_PLL_O)
		else $error("bit clock reference without PLL");
	pll_enable_a: assert property (
		PLL_ENABLE_O |-> SYSCLK_FROM_PLL_O)
		else $error("PLL powered while bypassed");
	bypass_ignore_a: assert property (
		!SYSCLK_FROM_PLL_O |-> PLL_FREQ_CODE_O == 2'h0 && !PLL_REF_IS_BCLK_O)
		else $error("bypass still uses reference fields");
	run_clean_a: assert property (
		DATAPATH_RUN_O |-> !CONFIG_ERROR_O)
		else $error("datapath runs on refused setup");
	strobe_pulse_a: assert property (
		CONVERT_STROBE_O |=> !CONVERT_STROBE_O)
		else $error("sample strobe longer than one cycle");
	strobe_run_a: assert property (
		CONVERT_STROBE_O |-> DATAPATH_RUN_O)
		else $error("sample strobe while datapath idle");
	auto_ref_a: assert property (
		AUTODETECT_ON_O && DATAPATH_RUN_O |-> !PLL_REF_IS_BCLK_O)
		else $error("autodetect running on bit clock reference");
	fs_strobe_a: assert property (
		fs_rise_s |-> ##[2:5] CONVERT_STROBE_O)
		else $error("no sample strobe after frame sync");
	setup_hold_a: assert property (
		$changed(SYSCLK_FROM_PLL_O) && !HW_MODE_STRAP_I
		&& !$past(SYS_RST_I, 3) |-> en_rise_s)
		else $error("clock setup changed without enable edge");
endmodule : acs_clk_sel_checker

bind acs_clk_sel acs_clk_sel_checker acs_clk_sel_checker_i (.*);

// ==== test/acs_clock_src.sv ====
// Model of the external clock source: master, bit clock, frame sync, lock
module acs_clock_src (
	input  wire logic pll_en_i,  // PLL powered by the block
	output logic      mclk_o,    // Master clock, free running
	output logic      bclk_o,    // Bit clock, 160 ns period
	output logic      fsync_o,   // Frame sync, one per 64 bit clocks
	output logic      lock_o     // PLL lock, rises 200 ns after power
);
	timeunit 1ns;
	timeprecision 100ps;
	int tick;  // Common timebase of all three clocks
	// Lock follows PLL power, late on rise, at once on fall
	assign #(200, 0) lock_o = pll_en_i;
	// All clocks from one timebase, locked, off the core edges
	initial begin
		tick = 0;
		mclk_o = 1'b0;
		bclk_o = 1'b0;
		fsync_o = 1'b0;
		#1;
		forever begin
			#10;
			tick++;
			mclk_o = ~mclk_o;
			bclk_o = tick[3];
			fsync_o = tick[9];
		end
	end
endmodule : acs_clock_src

// ==== test/acs_clk_sel_tb_top.sv ====
// Self-checking bench of the system clock select block
module acs_clk_sel_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic REF_CLK_I = 1'b0, SYS_RST_I = 1'b1, HW_MODE_STRAP_I = 1'b0;
	logic [1:0] CLOCK_SETUP_STRAP_PIN_I = 2'h0, PLL_INPUT_FREQ_CODE_I = 2'h0;
	logic [1:0] AUDIO_SERIAL_PORT_FORMAT_I = 2'h0, PLL_FREQ_CODE_O;
	logic [3:0] RATE_SELECT_STRAP_PIN_I = 4'h3, SAMPLE_RATE_I = 4'h3;
	logic [3:0] ACTIVE_RATE_O;
	logic GLOBAL_EN_I = 1'b0, CORE_CLOCK_SOURCE_SEL_I = 1'b0;
	logic PLL_INPUT_SOURCE_SEL_I = 1'b1;
	logic AUDIO_SERIAL_PORT_SECONDARY_I = 1'b1;
	logic MCLK_I, BCLK_I, FSYNC_I, PLL_LOCK_I, PLL_ENABLE_O;
	logic SYSCLK_FROM_PLL_O, PLL_REF_IS_BCLK_O, BASE_IS_48K_O;
	logic AUTODETECT_ON_O, CONFIG_ERROR_O, DATAPATH_RUN_O, CONVERT_STROBE_O;
	int fail_count = 0;
	int cmp_count = 0;
	always #2 REF_CLK_I = ~REF_CLK_I;
	acs_clk_sel #(.SETTLE_CYCLES(20)) acs_clk_sel_i (.*);
	acs_clock_src acs_clock_src_i (.pll_en_i(PLL_ENABLE_O), .mclk_o(MCLK_I),
		.bclk_o(BCLK_I), .fsync_o(FSYNC_I), .lock_o(PLL_LOCK_I));
	// Wait n edges, then let their updates land
	task automatic cyc(input int n);
		repeat (n) @(posedge REF_CLK_I);
		#1;
	endtask : cyc
	task automatic chk(input string nm, input logic [3:0] exp, got);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected %s: expected %h, seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic do_reset(input logic hw, input logic [1:0] setup);
		@(posedge REF_CLK_I);
		GLOBAL_EN_I <= 1'b0;
		SYS_RST_I <= 1'b1;
		HW_MODE_STRAP_I <= hw;
		CLOCK_SETUP_STRAP_PIN_I <= setup;
		repeat (10) @(posedge REF_CLK_I);
		SYS_RST_I <= 1'b0;
		cyc(10);
	endtask : do_reset
	// Bounded wait for the datapath, then for a sample strobe
	task automatic wait_run(input logic strobe);
		int n;
		n = 0;
		while (DATAPATH_RUN_O !== 1'b1 && n < 9000) begin
			cyc(1);
			n++;
		end
		chk("run", 4'h1, DATAPATH_RUN_O);
		n = 0;
		while (strobe && CONVERT_STROBE_O !== 1'b1 && n < 6000) begin
			cyc(1);
			n++;
		end
		if (strobe) chk("strobe", 4'h1, CONVERT_STROBE_O);
	endtask : wait_run
	// Software setup: fields, enable edge, expected outcome
	task automatic sw_case(input logic src, rsel, input logic [1:0] fq,
		input logic [3:0] rt, input logic sec, input logic [1:0] fm,
		input logic e_pll, e_bclk, input logic [1:0] e_code,
		input logic e_b48, input logic [3:0] e_rate, input logic e_err);
		@(posedge REF_CLK_I);
		GLOBAL_EN_I <= 1'b0;
		CORE_CLOCK_SOURCE_SEL_I <= src;
		PLL_INPUT_SOURCE_SEL_I <= rsel;
		PLL_INPUT_FREQ_CODE_I <= fq;
		SAMPLE_RATE_I <= rt;
		AUDIO_SERIAL_PORT_SECONDARY_I <= sec;
		AUDIO_SERIAL_PORT_FORMAT_I <= fm;
		@(posedge REF_CLK_I);
		GLOBAL_EN_I <= 1'b1;
		cyc(6);
		chk("error", {3'h0, e_err}, CONFIG_ERROR_O);
		if (e_err) chk("run", 4'h0, DATAPATH_RUN_O);
		else begin
			chk("pll", {3'h0, e_pll}, SYSCLK_FROM_PLL_O);
			chk("bclk ref", {3'h0, e_bclk}, PLL_REF_IS_BCLK_O);
			chk("freq code", {2'h0, e_code}, PLL_FREQ_CODE_O);
			wait_run(1'b1);
			chk("pll enable", {3'h0, e_pll}, PLL_ENABLE_O);
			chk("auto", {3'h0, rt == acs_pkg::RATE_AUTO}, AUTODETECT_ON_O);
			chk("base 48k", {3'h0, e_b48}, BASE_IS_48K_O);
			chk("rate", e_rate, ACTIVE_RATE_O);
		end
	endtask : sw_case
	task automatic final_report();
		$display("checks %0d, mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : final_report
	// Main sequence: software setups, then each hardware strap
	initial begin
		do_reset(1'b0, 2'h0);
		sw_case(
			1'b1, 1'b1, 2'h2, acs_pkg::RATE_48K, 1'b1, 2'h0,
			1'b1, 1'b0, 2'h2, 1'b1, acs_pkg::RATE_48K, 1'b0);
		@(posedge REF_CLK_I);
		CORE_CLOCK_SOURCE_SEL_I <= 1'b0;
		PLL_INPUT_FREQ_CODE_I <= 2'h0;
		cyc(6);
		chk("held pll", 4'h1, SYSCLK_FROM_PLL_O);
		chk("held code", 4'h2, PLL_FREQ_CODE_O);
		sw_case(
			1'b0, 1'b1, 2'h3, acs_pkg::RATE_44K1, 1'b0, 2'h1,
			1'b0, 1'b0, 2'h0, 1'b0, acs_pkg::RATE_44K1, 1'b0);
		sw_case(
			1'b1, 1'b0, 2'h1, acs_pkg::RATE_96K, 1'b1, 2'h1,
			1'b1, 1'b1, 2'h1, 1'b1, acs_pkg::RATE_96K, 1'b0);
		sw_case(
			1'b1, 1'b1, 2'h3, acs_pkg::RATE_768K, 1'b1, 2'h3,
			1'b1, 1'b0, 2'h3, 1'b1, acs_pkg::RATE_768K, 1'b0);
		sw_case(
			1'b1, 1'b1, 2'h2, acs_pkg::RATE_AUTO, 1'b1, 2'h0,
			1'b1, 1'b0, 2'h2, 1'b1, acs_pkg::RATE_96K, 1'b0);
		sw_case(
			1'b1, 1'b0, 2'h0, acs_pkg::RATE_AUTO, 1'b1, 2'h0,
			1'b0, 1'b0, 2'h0, 1'b0, 4'h0, 1'b1);
		sw_case(
			1'b1, 1'b0, 2'h3, acs_pkg::RATE_48K, 1'b0, 2'h0,
			1'b0, 1'b0, 2'h0, 1'b0, 4'h0, 1'b1);
		sw_case(
			1'b1, 1'b0, 2'h1, acs_pkg::RATE_96K, 1'b1,
			acs_pkg::FMT_TDM_MAX, 1'b0, 1'b0, 2'h0, 1'b0, 4'h0, 1'b1);
		sw_case(
			1'b1, 1'b1, 2'h2, 4'hc, 1'b1, 2'h0,
			1'b0, 1'b0, 2'h0, 1'b0, 4'h0, 1'b1);
		// Good setup straight after a refused one must run
		sw_case(
			1'b0, 1'b1, 2'h0, acs_pkg::RATE_48K, 1'b1, 2'h0,
			1'b0, 1'b0, 2'h0, 1'b1, acs_pkg::RATE_48K, 1'b0);
		@(posedge REF_CLK_I);
		AUDIO_SERIAL_PORT_SECONDARY_I <= 1'b1;
		AUDIO_SERIAL_PORT_FORMAT_I <= 2'h0;
		for (int s = 0; s < 4; s++) begin
			do_reset(1'b1, s[1:0]);
			wait_run(1'b1);
			chk("hw pll", {3'h0, s != 1}, SYSCLK_FROM_PLL_O);
			chk("hw bclk", {3'h0, s == 0}, PLL_REF_IS_BCLK_O);
			chk("hw code", s[1] ? {3'h1, s[0]} : 4'h0,
				PLL_FREQ_CODE_O);
			@(posedge REF_CLK_I);
			CLOCK_SETUP_STRAP_PIN_I <= ~s[1:0];
			cyc(6);
			chk("hw held", {3'h0, s != 1}, SYSCLK_FROM_PLL_O);
		end
		@(posedge REF_CLK_I);
		RATE_SELECT_STRAP_PIN_I <= acs_pkg::RATE_AUTO;
		do_reset(1'b1, acs_pkg::SETUP_BCLK64);
		cyc(10);
		chk("hw auto bclk", 4'h1, CONFIG_ERROR_O);
		final_report();
	end
	// Watchdog beyond the longest expected run
	initial begin
		#400000;
		fail_count++;
		final_report();
	end
endmodule : acs_clk_sel_tb_top
